/* core/sts_pkg.sv */
package sts_pkg;
	// ****************************************
	// apb register map
	// ****************************************
	localparam logic [7:0]  ADDR_COMPTIME  = 8'h00;
	localparam logic [7:0]  ADDR_LOGSEL    = 8'h04;
	localparam logic [7:0]  ADDR_LOGDATA   = 8'h08;
	localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
	localparam logic [7:0]  ADDR_LOGCNT    = 8'h10;
	localparam logic [15:0] COMPTIME_RST   = 16'hFFFF; // means 65 s or longer
	localparam int          EXT_TIME_S     = 65;
	// ****************************************
	// scsi status, sense keys and codes
	// ****************************************
	localparam logic [7:0]  STAT_GOOD      = 8'h00;
	localparam logic [7:0]  STAT_CHECK     = 8'h02;
	localparam logic [3:0]  KEY_NONE       = 4'h0;
	localparam logic [3:0]  KEY_NOT_READY  = 4'h2;
	localparam logic [3:0]  KEY_HW_ERR     = 4'h4;
	localparam logic [3:0]  KEY_ILLEGAL    = 4'h5;
	localparam logic [7:0]  ASC_NR         = 8'h04;
	localparam logic [7:0]  ASCQ_NR_TEST   = 8'h09;
	localparam logic [7:0]  ASC_FAILED     = 8'h3E;
	localparam logic [7:0]  ASCQ_FAILED    = 8'h03;
	localparam logic [7:0]  ASC_BAD_FIELD  = 8'h24;
	localparam logic [7:0]  ASCQ_ZERO      = 8'h00;
	// ****************************************
	// function codes, results, command kinds
	// ****************************************
	localparam logic [2:0]  FC_NONE        = 3'b000;
	localparam logic [2:0]  FC_BG_SHORT    = 3'b001;
	localparam logic [2:0]  FC_BG_EXT      = 3'b010;
	localparam logic [2:0]  FC_BG_ABORT    = 3'b100;
	localparam logic [2:0]  FC_FG_SHORT    = 3'b101;
	localparam logic [2:0]  FC_FG_EXT      = 3'b110;
	localparam logic [3:0]  RES_OK         = 4'h0;
	localparam logic [3:0]  RES_ABORT_DIAG = 4'h1;
	localparam logic [3:0]  RES_ABORT_OTH  = 4'h2;
	localparam logic [3:0]  RES_FAIL_SEG   = 4'h7;
	localparam logic [3:0]  RES_RUNNING    = 4'hF;
	localparam logic [2:0]  CMD_OTHER      = 3'd0;
	localparam logic [2:0]  CMD_INQUIRY    = 3'd1;
	localparam logic [2:0]  CMD_REPORT_LUN = 3'd2;
	localparam logic [2:0]  CMD_REQ_SENSE  = 3'd3;
	localparam logic [2:0]  CMD_SEND_DIAG  = 3'd4;
	localparam logic [2:0]  CMD_WB_UCODE   = 3'd5;
	localparam logic [2:0]  CMD_FORMAT     = 3'd6;
	localparam logic [2:0]  CMD_START_STOP = 3'd7;
	// ****************************************
	// step codes for the mechanical engine
	// ****************************************
	localparam logic [3:0]  STEP_NONE      = 4'd0;
	localparam logic [3:0]  STEP_SPIN      = 4'd1;
	localparam logic [3:0]  STEP_WRC       = 4'd2;
	localparam logic [3:0]  STEP_SEEK      = 4'd3;
	localparam logic [3:0]  STEP_SMART     = 4'd4;
	localparam logic [3:0]  STEP_HEAD      = 4'd5;
	localparam logic [3:0]  STEP_RVERIFY   = 4'd6;
	localparam logic [3:0]  STEP_SVERIFY   = 4'd7;
	localparam logic [15:0] SEEK_COUNT     = 16'd256;
	localparam logic [15:0] RVERIFY_COUNT  = 16'd4000;
	localparam logic [15:0] SHORT_FIRST_MB = 16'd300;
	localparam logic [15:0] SHORT_LAST_MB  = 16'd100;
	// ****************************************
	// step index list, log and timing
	// ****************************************
	localparam logic [3:0]  IDX_READY      = 4'd0;
	localparam logic [3:0]  IDX_SPIN       = 4'd1;
	localparam logic [3:0]  IDX_SEEK       = 4'd3;
	localparam logic [3:0]  IDX_FMT        = 4'd5;
	localparam logic [3:0]  IDX_LAST       = 4'd9;
	localparam int          LOG_DEPTH      = 20;
	localparam logic [4:0]  LOG_TOP        = 5'd19;
	localparam int          CLK_HZ         = 10_000_000;
	localparam int          SUSPEND_S      = 2;
	localparam int          SUSPEND_CYC    = CLK_HZ * SUSPEND_S;
endpackage

/* core/sts_sequencer.sv */
`timescale 1ns/1ns
// Overview of operation
// - self-test bit runs default test; GOOD on pass, CHECK on failure
// - default test: spindle speed, per-head reserved-area write/read/compare, 256 seeks
// - extended test duration reported; FFFFh means 65 seconds or more
// - foreground short/extended test holds status until the test ends
// - foreground test: all but inquiry, report luns, request sense get NOT READY
// - foreground error is logged and answered HARDWARE ERROR, failed self-test
// - abort task, abort task set, clear task set stop foreground test, log updated
// - background request gets status once the command block is validated
// - after that status, log entry gets function code and result 0Fh
// - background running: reject self-test bit or codes other than 000b, 100b
// - background test pauses for ordinary commands within 2 seconds
// - code 100b, microcode write, format, start/stop end background test, log updated
// - running test answers request sense NOT READY with progress indication
// - log keeps the twenty most recently started tests
// - default test never writes the log
// - short and extended run segments 1h to 8h in order, numbers reported
// - random verify segment does 4000 verifies, fails on uncorrectable error
// - segment 7h verifies first 300MB and last 100 MB, or every block; short test requests only the first 300MB
// - format check segment fails when medium is format corrupted
// - head check writes then reads every head in the reserved area
module sts_sequencer import sts_pkg::*; #(
	parameter int SUSP_LIMIT = SUSPEND_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [2:0]  cmd_kind,
	input  wire logic        cmd_default_test_request_bit,
	input  wire logic [2:0]  cmd_func_code,
	input  wire logic        tmf_abort,
	output logic             rsp_valid,
	output logic      [7:0]  rsp_status,
	output logic      [3:0]  rsp_sense_key,
	output logic      [7:0]  rsp_asc,
	output logic      [7:0]  rsp_ascq,
	output logic      [15:0] rsp_progress,
	output logic             fwd_valid,
	output logic      [2:0]  fwd_kind,
	input  wire logic        fwd_done,
	output logic             step_start,
	output logic             step_abort,
	output logic      [3:0]  step_code,
	output logic      [15:0] step_count,
	output logic             step_full,
	input  wire logic        step_done,
	input  wire logic        step_fail,
	input  wire logic        drive_ready,
	input  wire logic        media_fmt_corrupt,
	output logic      [15:0] ext_completion_time,
	output logic             test_busy
);
	typedef enum logic [1:0] {MD_IDLE, MD_DEFAULT, MD_FG, MD_BG} sts_mode_e;
	typedef enum logic [2:0] {ST_IDLE, ST_INIT, ST_ISSUE, ST_WAIT, ST_DONE} sts_state_e;

	// ****************************************
	// helpers
	// ****************************************
	// segment number of a step index
	function automatic logic [3:0] idx_seg(input logic [3:0] i);
		case (i)
			4'd0:                idx_seg = 4'h1;
			4'd1, 4'd2, 4'd3:    idx_seg = 4'h2;
			4'd4:                idx_seg = 4'h3;
			4'd5:                idx_seg = 4'h4;
			4'd6:                idx_seg = 4'h5;
			4'd7:                idx_seg = 4'h6;
			4'd8:                idx_seg = 4'h7;
			default:             idx_seg = 4'h8;
		endcase
	endfunction
	// engine step of a step index
	function automatic logic [3:0] idx_step(input logic [3:0] i);
		case (i)
			4'd1:          idx_step = STEP_SPIN;
			4'd2:          idx_step = STEP_WRC;
			4'd3:          idx_step = STEP_SEEK;
			4'd4, 4'd9:    idx_step = STEP_SMART;
			4'd6:          idx_step = STEP_HEAD;
			4'd7:          idx_step = STEP_RVERIFY;
			4'd8:          idx_step = STEP_SVERIFY;
			default:       idx_step = STEP_NONE;
		endcase
	endfunction
	// ring pointer step back
	function automatic logic [4:0] ring_back(input logic [4:0] p, input logic [4:0] n);
		logic [5:0] s;
		s = {1'b0, p} + 6'd20 - {1'b0, n};
		ring_back = (s >= 6'd20) ? 5'(s - 6'd20) : s[4:0];
	endfunction

	sts_mode_e  mode_q;
	sts_state_e state_q;
	logic [3:0]  idx_q;
	logic        ext_q;
	logic [2:0]  func_q;
	logic [3:0]  res_q;
	logic [3:0]  fseg_q;
	logic        tmf_end_q;
	logic        susp_q;
	logic [24:0] susp_cnt_q;
	logic [11:0] log_q [LOG_DEPTH];
	logic [4:0]  wptr_q;
	logic [4:0]  cur_q;
	logic [4:0]  cnt_q;
	logic [15:0] comptime_q;
	logic [4:0]  logsel_q;
	logic        ack_q;
	logic [31:0] prdata_q;
	logic        rsp_valid_q;
	logic [7:0]  rsp_status_q;
	logic [3:0]  rsp_key_q;
	logic [7:0]  rsp_asc_q;
	logic [7:0]  rsp_ascq_q;
	logic [15:0] rsp_prog_q;
	logic        fwd_valid_q;
	logic [2:0]  fwd_kind_q;
	logic        step_start_q;
	logic        step_abort_q;
	logic [3:0]  step_code_q;
	logic [15:0] step_count_q;
	logic        step_full_q;

	// ****************************************
	// command decode
	// ****************************************
	wire        running   = (mode_q != MD_IDLE);
	wire        take      = cmd_valid & cmd_ready;
	wire        is_sd     = (cmd_kind == CMD_SEND_DIAG);
	wire        sbit      = cmd_default_test_request_bit;
	wire        fc_fg     = (cmd_func_code == FC_FG_SHORT) | (cmd_func_code == FC_FG_EXT);
	wire        fc_bg     = (cmd_func_code == FC_BG_SHORT) | (cmd_func_code == FC_BG_EXT);
	wire        exempt    = (cmd_kind == CMD_INQUIRY) | (cmd_kind == CMD_REPORT_LUN);
	wire        is_rs     = (cmd_kind == CMD_REQ_SENSE);
	wire        bg_kill   = (is_sd & ~sbit & (cmd_func_code == FC_BG_ABORT))
		| (cmd_kind == CMD_WB_UCODE) | (cmd_kind == CMD_FORMAT)
		| (cmd_kind == CMD_START_STOP);
	wire        bg_reject = is_sd & (sbit | ((cmd_func_code != FC_NONE)
		& (cmd_func_code != FC_BG_ABORT)));
	wire        fg_run    = (mode_q == MD_FG) | (mode_q == MD_DEFAULT);
	wire        bg_run    = (mode_q == MD_BG);
	wire        in_flight = (state_q == ST_WAIT);
	wire [3:0]  seg_now   = idx_seg(idx_q);
	wire [15:0] progress  = {3'(seg_now - 4'h1), 13'h0000};
	wire [3:0]  last_idx  = (mode_q == MD_DEFAULT) ? IDX_SEEK : IDX_LAST;
	wire        susp_late = susp_q & in_flight & (susp_cnt_q == 25'(SUSP_LIMIT - 1));
	// immediate pass or fail for segments checked inline
	wire        inline_chk = (idx_q == IDX_READY) | (idx_q == IDX_FMT);
	wire        inline_bad = (idx_q == IDX_READY) ? ~drive_ready : media_fmt_corrupt;
	wire        bg_abort  = take & bg_run & ~bg_reject & bg_kill;
	wire        fg_abort  = tmf_abort & fg_run & (state_q != ST_DONE);
	wire        log_write = ((state_q == ST_DONE) & (mode_q != MD_DEFAULT))
		| (state_q == ST_INIT);

	assign cmd_ready = (state_q != ST_DONE) & ~(fg_run & tmf_abort);

	// ****************************************
	// sequencer
	// ****************************************
	// mode, step walk and outcome
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q    <= MD_IDLE;
			state_q   <= ST_IDLE;
			idx_q     <= 4'h0;
			ext_q     <= 1'b0;
			func_q    <= FC_NONE;
			res_q     <= RES_OK;
			fseg_q    <= 4'h0;
			tmf_end_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (take & is_sd & sbit) begin
						mode_q  <= MD_DEFAULT;
						idx_q   <= IDX_SPIN;
						state_q <= ST_ISSUE;
					end else if (take & is_sd & (fc_fg | fc_bg)) begin
						mode_q  <= fc_fg ? MD_FG : MD_BG;
						ext_q   <= cmd_func_code[1];
						func_q  <= cmd_func_code;
						idx_q   <= IDX_READY;
						state_q <= ST_INIT;
					end
					res_q     <= RES_OK;
					fseg_q    <= 4'h0;
					tmf_end_q <= 1'b0;
				end
				ST_INIT: begin
					state_q <= ST_ISSUE;
				end
				ST_ISSUE: begin
					if (inline_chk & inline_bad) begin
						res_q   <= RES_FAIL_SEG;
						fseg_q  <= seg_now;
						state_q <= ST_DONE;
					end else if (inline_chk) begin
						idx_q <= idx_q + 4'h1;
					end else if (!susp_q) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (susp_late) begin
						state_q <= ST_ISSUE;
					end else if (step_done & step_fail) begin
						res_q   <= RES_FAIL_SEG;
						fseg_q  <= seg_now;
						state_q <= ST_DONE;
					end else if (step_done & (idx_q == last_idx)) begin
						state_q <= ST_DONE;
					end else if (step_done) begin
						idx_q   <= idx_q + 4'h1;
						state_q <= ST_ISSUE;
					end
				end
				ST_DONE: begin
					mode_q  <= MD_IDLE;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
			if (bg_abort | fg_abort) begin
				res_q     <= (bg_abort & is_sd) ? RES_ABORT_DIAG : RES_ABORT_OTH;
				fseg_q    <= seg_now;
				tmf_end_q <= fg_abort;
				state_q   <= ST_DONE;
			end
		end
	end

	// background suspension and watchdog
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			susp_q     <= 1'b0;
			susp_cnt_q <= 25'h000_0000;
		end else begin
			if (take & bg_run & ~bg_kill & ~is_sd & ~is_rs)
				susp_q <= 1'b1;
			else if (fwd_done | ~bg_run)
				susp_q <= 1'b0;
			susp_cnt_q <= (susp_q & in_flight) ? susp_cnt_q + 25'h000_0001 : 25'h000_0000;
		end
	end

	// ****************************************
	// command answers and forwarding
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid_q  <= 1'b0;
			rsp_status_q <= STAT_GOOD;
			rsp_key_q    <= KEY_NONE;
			rsp_asc_q    <= 8'h00;
			rsp_ascq_q   <= 8'h00;
			rsp_prog_q   <= 16'h0000;
			fwd_valid_q  <= 1'b0;
			fwd_kind_q   <= CMD_OTHER;
		end else begin
			rsp_valid_q  <= 1'b0;
			rsp_status_q <= STAT_GOOD;
			rsp_key_q    <= KEY_NONE;
			rsp_asc_q    <= 8'h00;
			rsp_ascq_q   <= 8'h00;
			rsp_prog_q   <= 16'h0000;
			fwd_valid_q  <= 1'b0;
			fwd_kind_q   <= cmd_kind;
			if ((state_q == ST_DONE) & fg_run & ~tmf_end_q) begin
				rsp_valid_q <= 1'b1;
				if (res_q != RES_OK) begin
					rsp_status_q <= STAT_CHECK;
					rsp_key_q    <= KEY_HW_ERR;
					rsp_asc_q    <= ASC_FAILED;
					rsp_ascq_q   <= ASCQ_FAILED;
				end
			end else if (take & running & is_rs) begin
				rsp_valid_q  <= 1'b1;
				rsp_key_q    <= KEY_NOT_READY;
				rsp_asc_q    <= ASC_NR;
				rsp_ascq_q   <= ASCQ_NR_TEST;
				rsp_prog_q   <= progress;
			end else if (take & ((fg_run & ~exempt) | (bg_run & bg_reject))) begin
				rsp_valid_q  <= 1'b1;
				rsp_status_q <= STAT_CHECK;
				rsp_key_q    <= KEY_NOT_READY;
				rsp_asc_q    <= ASC_NR;
				rsp_ascq_q   <= ASCQ_NR_TEST;
			end else if (take & is_sd & ~(~running & (sbit | fc_fg))) begin
				rsp_valid_q  <= 1'b1;
				if (~running & ~sbit & ~fc_bg & (cmd_func_code != FC_NONE)
					& (cmd_func_code != FC_BG_ABORT)) begin
					rsp_status_q <= STAT_CHECK;
					rsp_key_q    <= KEY_ILLEGAL;
					rsp_asc_q    <= ASC_BAD_FIELD;
					rsp_ascq_q   <= ASCQ_ZERO;
				end
			end else if (take & ~running & is_rs) begin
				rsp_valid_q <= 1'b1;
			end else if (take & ~is_sd) begin
				fwd_valid_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// step engine requests
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_start_q <= 1'b0;
			step_abort_q <= 1'b0;
			step_code_q  <= STEP_NONE;
			step_count_q <= 16'h0000;
			step_full_q  <= 1'b0;
		end else begin
			step_start_q <= (state_q == ST_ISSUE) & ~inline_chk & ~susp_q
				& ~bg_abort & ~fg_abort;
			step_abort_q <= in_flight & (susp_late | bg_abort | fg_abort);
			step_code_q  <= idx_step(idx_q);
			step_full_q  <= ext_q;
			case (idx_step(idx_q))
				STEP_SEEK:    step_count_q <= SEEK_COUNT;
				STEP_RVERIFY: step_count_q <= RVERIFY_COUNT;
				STEP_SVERIFY: step_count_q <= ext_q ? 16'h0000 : SHORT_FIRST_MB;
				default:      step_count_q <= 16'h0000;
			endcase
		end
	end

	// ****************************************
	// results log
	// ****************************************
	// newest entry sits just behind the write pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_q <= 5'h00;
			cur_q  <= 5'h00;
			cnt_q  <= 5'h00;
		end else if (state_q == ST_INIT) begin
			cur_q  <= wptr_q;
			wptr_q <= (wptr_q == LOG_TOP) ? 5'h00 : wptr_q + 5'h01;
			cnt_q  <= (cnt_q == 5'(LOG_DEPTH)) ? cnt_q : cnt_q + 5'h01;
		end
	end

	always_ff @(posedge pclk) begin
		if (log_write)
			log_q[(state_q == ST_INIT) ? wptr_q : cur_q] <= (state_q == ST_INIT)
				? {1'b0, func_q, RES_RUNNING, 4'h0}
				: {1'b0, func_q, res_q, fseg_q};
	end

	// ****************************************
	// apb slave, one wait state
	// ****************************************
	wire        apb_acc  = psel & penable;
	wire        wr_en    = apb_acc & ack_q & pwrite;
	wire        addr_ok  = (paddr == ADDR_COMPTIME) | (paddr == ADDR_LOGSEL)
		| (paddr == ADDR_LOGDATA) | (paddr == ADDR_STATUS) | (paddr == ADDR_LOGCNT);
	wire [4:0]  rd_slot  = ring_back(wptr_q, logsel_q + 5'h01);
	wire        sel_ok   = (logsel_q < cnt_q);
	wire [31:0] rd_mux   = (paddr == ADDR_COMPTIME) ? {16'h0000, comptime_q}
		: (paddr == ADDR_LOGSEL)  ? {27'h000_0000, logsel_q}
		: (paddr == ADDR_LOGDATA) ? (sel_ok ? {19'h0_0000, 1'b1, log_q[rd_slot]}
			: 32'h0000_0000)
		: (paddr == ADDR_STATUS)  ? {8'h00, progress, susp_q, mode_q, 1'b0, res_q}
		: (paddr == ADDR_LOGCNT)  ? {27'h000_0000, cnt_q}
		: 32'h0000_0000;

	// register writes and captured read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q      <= 1'b0;
			prdata_q   <= 32'h0000_0000;
			comptime_q <= COMPTIME_RST;
			logsel_q   <= 5'h00;
		end else begin
			ack_q <= apb_acc & ~ack_q;
			if (apb_acc & ~ack_q)
				prdata_q <= rd_mux;
			if (wr_en & (paddr == ADDR_COMPTIME))
				comptime_q <= pwdata[15:0];
			if (wr_en & (paddr == ADDR_LOGSEL))
				logsel_q <= pwdata[4:0];
		end
	end

	assign pready              = apb_acc & ack_q;
	assign pslverr             = apb_acc & ack_q & ~addr_ok;
	assign prdata              = prdata_q;
	assign ext_completion_time = comptime_q;
	assign rsp_valid           = rsp_valid_q;
	assign rsp_status          = rsp_status_q;
	assign rsp_sense_key       = rsp_key_q;
	assign rsp_asc             = rsp_asc_q;
	assign rsp_ascq            = rsp_ascq_q;
	assign rsp_progress        = rsp_prog_q;
	assign fwd_valid           = fwd_valid_q;
	assign fwd_kind            = fwd_kind_q;
	assign step_start          = step_start_q;
	assign step_abort          = step_abort_q;
	assign step_code           = step_code_q;
	assign step_count          = step_count_q;
	assign step_full           = step_full_q;
	assign test_busy           = running;

	// ****************************************
	// assertions
	// ****************************************
	sequence s_bg_req;
		take & ~running & is_sd & ~sbit & fc_bg;
	endsequence
	sequence s_bg_status;
		rsp_valid & (rsp_status == STAT_GOOD);
	endsequence

	a_bg_status_first: assert property (@(posedge pclk) disable iff (!presetn)
		s_bg_req |=> s_bg_status ##1 (log_q[cur_q][7:4] == RES_RUNNING))
		else $error("background status or log init late");
	a_fg_not_ready: assert property (@(posedge pclk) disable iff (!presetn)
		take & fg_run & ~exempt & ~is_rs |=> rsp_valid & (rsp_sense_key == KEY_NOT_READY))
		else $error("foreground test let a command through");
	a_bg_reject_diag: assert property (@(posedge pclk) disable iff (!presetn)
		take & bg_run & bg_reject |=> rsp_valid & (rsp_status == STAT_CHECK)
			& (rsp_ascq == ASCQ_NR_TEST))
		else $error("background run accepted a diagnostic");
	a_default_no_log: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_q == MD_DEFAULT) |-> $stable(cnt_q) && !log_write)
		else $error("default test wrote the log");
	a_fmt_check_fail: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_ISSUE) & (idx_q == IDX_FMT) & media_fmt_corrupt & ~bg_abort
			& ~fg_abort |=> (state_q == ST_DONE) && (fseg_q == 4'h4))
		else $error("format corrupted medium passed");
	a_tmf_stops_fg: assert property (@(posedge pclk) disable iff (!presetn)
		fg_abort |=> (state_q == ST_DONE) ##1 (mode_q == MD_IDLE) & !rsp_valid)
		else $error("task management did not end foreground test");
	a_fg_fail_hw: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_WAIT) & (mode_q == MD_FG) & step_done & step_fail & ~fg_abort
			|=> ##1 rsp_valid & (rsp_sense_key == KEY_HW_ERR) & (rsp_asc == ASC_FAILED))
		else $error("foreground failure not reported");
	a_seek_count: assert property (@(posedge pclk) disable iff (!presetn)
		step_start & (step_code == STEP_SEEK) |-> (step_count == SEEK_COUNT))
		else $error("seek step count wrong");
	a_rs_progress: assert property (@(posedge pclk) disable iff (!presetn)
		take & running & is_rs |=> rsp_valid & (rsp_progress == $past(progress)))
		else $error("request sense lacks progress");
endmodule // sts_sequencer

/* tb/sts_engine_model.sv */
`timescale 1ns/1ns
// ****************************************
// mechanical engine stand-in
// ****************************************
module sts_engine_model import sts_pkg::*; (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       step_start,
	input  wire logic       step_abort,
	input  wire logic [3:0] step_code,
	input  wire logic [3:0] fail_code,
	output logic            step_done,
	output logic            step_fail
);
	logic [4:0] wait_q;
	logic       busy_q;
	// answers each step after a fixed wait; abort drops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 5'h0;
			busy_q <= 1'b0;
			step_done <= 1'b0;
			step_fail <= 1'b0;
		end else begin
			step_done <= busy_q && wait_q == 5'h0 && !step_abort;
			step_fail <= busy_q && step_code == fail_code; // failure only when commanded
			if (step_start) begin
				busy_q <= 1'b1;
				wait_q <= 5'h14;
			end else if (step_abort || wait_q == 5'h0) begin
				busy_q <= 1'b0;
			end else begin
				wait_q <= wait_q - 5'h1;
			end
		end
	end
endmodule // sts_engine_model

/* tb/drive_self_test_sequencer_test.sv */
`timescale 1ns/1ns
module drive_self_test_sequencer_test import sts_pkg::*;;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic [7:0]  paddr = 0, rsp_status, rsp_asc, rsp_ascq;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, cmd_valid = 0, cmd_ready, cmd_bit = 0, tmf_abort = 0;
	logic [2:0]  cmd_kind = 0, cmd_fc = 0, fwd_kind;
	logic        rsp_valid, fwd_valid, fwd_done = 0, step_start, step_abort, step_full;
	logic        step_done, step_fail, test_busy, drive_ready = 1, media_fmt_corrupt = 0;
	logic [3:0]  rsp_sense_key, step_code, fail_code = 0;
	logic [15:0] rsp_progress, step_count, ext_completion_time;
	logic [27:0] rsp;
	logic [15:0] prog;
	int          err_total = 0, samples_checked = 0, cyc = 0;
	localparam logic [27:0] BUSY = {STAT_CHECK, KEY_NOT_READY, ASC_NR, ASCQ_NR_TEST};
	sts_sequencer #(.SUSP_LIMIT(16)) sts_sequencer_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_valid, .cmd_ready,
		.cmd_kind, .cmd_default_test_request_bit(cmd_bit), .cmd_func_code(cmd_fc), .tmf_abort,
		.rsp_valid, .rsp_status, .rsp_sense_key, .rsp_asc, .rsp_ascq, .rsp_progress,
		.fwd_valid, .fwd_kind, .fwd_done, .step_start, .step_abort, .step_code, .step_count,
		.step_full, .step_done, .step_fail, .drive_ready, .media_fmt_corrupt,
		.ext_completion_time, .test_busy);
	sts_engine_model sts_engine_model_i (.pclk, .presetn, .step_start, .step_abort,
		.step_code, .fail_code, .step_done, .step_fail);
	initial forever #50 pclk = ~pclk;
	// forwarded commands are served at once; hang guard
	always @(posedge pclk) begin
		fwd_done <= fwd_valid;
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			conclude();
		end
	end
	// step counts seen at the engine
	always @(negedge pclk) if (step_start && step_code inside {STEP_SEEK, STEP_RVERIFY})
		chk("count", step_count, step_code == STEP_SEEK ? SEEK_COUNT : RVERIFY_COUNT);
	// short sequential verify range
	always @(negedge pclk) if (step_start && step_code == STEP_SVERIFY)
		chk("seq", {step_full, step_count}, {1'b0, SHORT_FIRST_MB});
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic cmd(input logic [2:0] k, input logic b, input logic [2:0] f);
		cmd_valid <= 1;
		cmd_kind <= k;
		cmd_bit <= b;
		cmd_fc <= f;
		do @(posedge pclk); while (cmd_ready !== 1'b1);
		cmd_valid <= 0;
	endtask
	task automatic get_rsp;
		do @(negedge pclk); while (rsp_valid !== 1'b1);
		rsp = {rsp_status, rsp_sense_key, rsp_asc, rsp_ascq};
		prog = rsp_progress;
		@(posedge pclk);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, ADDR_COMPTIME, 0);
		chk("comptime", rd, 32'h0000_FFFF);
		apb(1, ADDR_COMPTIME, 32'h0000_0041);
		apb(0, ADDR_COMPTIME, 0);
		chk("comptime wr", rd, 32'h0000_0041);
		chk("ext time", ext_completion_time, 32'h0000_0041);
		apb(0, 8'h40, 0);
		chk("unmapped", {rd[30:0], se}, 32'h0000_0001);
		cmd(CMD_SEND_DIAG, 1, FC_NONE);
		get_rsp();
		chk("default", rsp, {STAT_GOOD, 20'h0_0000});
		apb(0, ADDR_LOGCNT, 0);
		chk("no log", rd, 32'h0000_0000);
		cmd(CMD_SEND_DIAG, 0, FC_FG_SHORT);
		@(posedge pclk);
		cmd(CMD_OTHER, 0, 0);
		get_rsp();
		chk("fg other", rsp, BUSY);
		cmd(CMD_REQ_SENSE, 0, 0);
		get_rsp();
		chk("fg sense", rsp, {STAT_GOOD, KEY_NOT_READY, ASC_NR, ASCQ_NR_TEST});
		chk("fg prog", prog, 32'h0000_2000);
		get_rsp();
		chk("fg done", rsp, {STAT_GOOD, 20'h0_0000});
		apb(0, ADDR_LOGDATA, 0);
		chk("fg log", rd[12:4], {1'b1, 1'b0, FC_FG_SHORT, RES_OK});
		fail_code <= STEP_HEAD;
		cmd(CMD_SEND_DIAG, 0, FC_FG_SHORT);
		get_rsp();
		chk("fg fail", rsp, {STAT_CHECK, KEY_HW_ERR, ASC_FAILED, ASCQ_FAILED});
		apb(0, ADDR_LOGDATA, 0);
		chk("fail log", rd[7:0], {RES_FAIL_SEG, 4'h5});
		fail_code <= 0;
		media_fmt_corrupt <= 1;
		cmd(CMD_SEND_DIAG, 0, FC_FG_SHORT);
		get_rsp();
		chk("fmt fail", rsp, {STAT_CHECK, KEY_HW_ERR, ASC_FAILED, ASCQ_FAILED});
		media_fmt_corrupt <= 0;
		apb(0, ADDR_LOGDATA, 0);
		chk("fmt log", rd[7:0], {RES_FAIL_SEG, 4'h4});
		cmd(CMD_SEND_DIAG, 0, FC_FG_EXT);
		repeat (10) @(posedge pclk);
		tmf_abort <= 1;
		@(posedge pclk);
		tmf_abort <= 0;
		@(negedge pclk);
		chk("tmf stop", {step_abort, step_full}, 2'b11);
		repeat (3) @(posedge pclk);
		apb(0, ADDR_LOGDATA, 0);
		chk("tmf log", rd[11:0], {1'b0, FC_FG_EXT, RES_ABORT_OTH, 4'h2});
		cmd(CMD_SEND_DIAG, 0, FC_BG_SHORT);
		get_rsp();
		chk("bg status", rsp, {STAT_GOOD, 20'h0_0000});
		chk("bg busy", test_busy, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		apb(0, ADDR_LOGDATA, 0);
		chk("bg log", rd[11:4], {1'b0, FC_BG_SHORT, RES_RUNNING});
		cmd(CMD_SEND_DIAG, 0, FC_BG_EXT);
		get_rsp();
		chk("bg code", rsp, BUSY);
		cmd(CMD_SEND_DIAG, 1, FC_NONE);
		get_rsp();
		chk("bg bit", rsp, BUSY);
		cmd(CMD_OTHER, 0, 0);
		@(negedge pclk);
		chk("bg fwd", {fwd_valid, fwd_kind}, {1'b1, CMD_OTHER});
		@(posedge pclk);
		cmd(CMD_SEND_DIAG, 0, FC_BG_ABORT);
		get_rsp();
		chk("bg abort", rsp, {STAT_GOOD, 20'h0_0000});
		repeat (3) @(posedge pclk);
		apb(0, ADDR_LOGDATA, 0);
		chk("abort log", rd[7:4], RES_ABORT_DIAG);
		cmd(CMD_SEND_DIAG, 0, FC_BG_SHORT);
		get_rsp();
		cmd(CMD_FORMAT, 0, 0);
		@(negedge pclk);
		chk("kill fwd", {fwd_valid, fwd_kind}, {1'b1, CMD_FORMAT});
		repeat (3) @(posedge pclk);
		apb(0, ADDR_LOGDATA, 0);
		chk("kill log", rd[7:4], RES_ABORT_OTH);
		chk("idle", test_busy, 32'h0000_0000);
		conclude();
	end
endmodule // drive_self_test_sequencer_test
